// ===== rdata_fifo_pkg.sv
// Purpose: Shared constants and ECC helpers for the read-data channel FIFO
// Assumes: One clock; payload is id, data, response, last and user bits
// Notes: Codeword is a Hamming code plus an overall parity bit at position 0
package rdata_fifo_pkg;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int CNT_W = ADDR_W + 1;
  localparam int THR_W = ADDR_W;
  localparam int ID_W = 4;
  localparam int DATA_W = 32;
  localparam int RESP_W = 2;
  localparam int USER_W = 1;
  localparam int PAY_W = ID_W + DATA_W + RESP_W + 1 + USER_W;
  localparam int PAR_W = 6;
  localparam int CW_W = PAY_W + PAR_W + 1;
  localparam int SB_POS = 3;
  localparam int DB_POS = 5;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [ADDR_W-1:0] PTR_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  function automatic logic [CW_W-1:0] ecc_encode(input logic [PAY_W-1:0] d);
    logic [CW_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[j];
        j++;
      end
    end
    for (int k = 0; k < PAR_W; k++) begin
      for (int i = 1; i < CW_W; i++) begin
        if ((((i >> k) & 1) == 1) && ((i & (i - 1)) != 0)) begin
          c[1 << k] = c[1 << k] ^ c[i];
        end
      end
    end
    c[0] = ^c[CW_W-1:1];
    return c;
  endfunction : ecc_encode

  function automatic logic [PAR_W-1:0] ecc_syndrome(input logic [CW_W-1:0] c);
    logic [PAR_W-1:0] s;
    s = '0;
    for (int i = 1; i < CW_W; i++) begin
      if (c[i]) begin
        s = s ^ PAR_W'(i);
      end
    end
    return s;
  endfunction : ecc_syndrome

  function automatic logic [PAY_W-1:0] ecc_extract(input logic [CW_W-1:0] c);
    logic [PAY_W-1:0] d;
    int j;
    d = '0;
    j = 0;
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = c[i];
        j++;
      end
    end
    return d;
  endfunction : ecc_extract
endpackage : rdata_fifo_pkg

// ===== rdata_fifo.sv
// Purpose: Read-data channel FIFO with status flags, counts and ECC
// Assumes: Single clock; thresholds held steady while reset is applied
// Notes: All outputs come from flip-flops; head word is pre-fetched
// Operation
// RULE1 - Full threshold comes in on its own input, set only during reset
// RULE2 - Empty threshold comes in on its own input, set only during reset
// RULE3 - With ECC on, single injection flips one stored bit on write
// RULE4 - With ECC on, double injection flips two stored bits on write
// RULE5 - Single-error output flags a corrected one-bit error on the read word
// RULE6 - Double-error output flags an uncorrectable two-bit error on the read word
// RULE7 - Overflow pulses one cycle after a write request refused while full
// RULE8 - A refused write leaves contents and pointers untouched
// RULE9 - Handshake blocks writes while full, so refusals only come from waiting
// RULE10 - Underflow pulses after a read request refused while empty, data untouched
// RULE11 - Handshake blocks reads while empty, so refusals only come from waiting
// RULE12 - Write-side count, log2 depth plus one bits, never under the true count
// RULE13 - An accepted write shows in the write-side count at the next edge
// RULE14 - Read-side count, log2 depth plus one bits, never over readable words
// RULE15 - A read shows in the read-side count at the next edge
// RULE16 - Common count of stored words, log2 depth plus one bits
// RULE17 - Programmable full asserts when count reaches the full threshold
// RULE18 - Programmable full clears when count falls below the full threshold
// RULE19 - Programmable empty asserts when count is at or below empty threshold
// RULE20 - Programmable empty clears when count rises above empty threshold
// RULE21 - Full-side outputs follow the write clock, empty-side the read clock; here both sides follow the single clk
`timescale 1ns/1ps
`default_nettype none
module rdata_fifo (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ecc_enable,
  input wire logic [rdata_fifo_pkg::ID_W-1:0] m_axi_rid,
  input wire logic [rdata_fifo_pkg::DATA_W-1:0] m_axi_rdata,
  input wire logic [rdata_fifo_pkg::RESP_W-1:0] m_axi_rresp,
  input wire logic m_axi_rlast,
  input wire logic [rdata_fifo_pkg::USER_W-1:0] m_axi_ruser,
  input wire logic m_axi_rvalid,
  output logic m_axi_rready,
  output logic [rdata_fifo_pkg::ID_W-1:0] s_axi_rid,
  output logic [rdata_fifo_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [rdata_fifo_pkg::RESP_W-1:0] s_axi_rresp,
  output logic s_axi_rlast,
  output logic [rdata_fifo_pkg::USER_W-1:0] s_axi_ruser,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [rdata_fifo_pkg::THR_W-1:0] prog_full_thresh,
  input wire logic [rdata_fifo_pkg::THR_W-1:0] prog_empty_thresh,
  input wire logic inject_single_err,
  input wire logic inject_double_err,
  output logic single_err,
  output logic double_err,
  output logic overflow,
  output logic underflow,
  output logic [rdata_fifo_pkg::CNT_W-1:0] wr_data_count,
  output logic [rdata_fifo_pkg::CNT_W-1:0] rd_data_count,
  output logic [rdata_fifo_pkg::CNT_W-1:0] data_count,
  output logic prog_full,
  output logic prog_empty
);
  localparam int CW_W = rdata_fifo_pkg::CW_W;
  localparam int PAY_W = rdata_fifo_pkg::PAY_W;
  localparam int ADDR_W = rdata_fifo_pkg::ADDR_W;
  localparam int CNT_W = rdata_fifo_pkg::CNT_W;
  localparam int THR_W = rdata_fifo_pkg::THR_W;

  logic rst_meta_q;
  logic rst_n_q;
  logic [THR_W-1:0] full_thr_q;
  logic [THR_W-1:0] empty_thr_q;
  logic [CW_W-1:0] mem_q [rdata_fifo_pkg::DEPTH];
  logic [ADDR_W-1:0] wr_ptr_q;
  logic [ADDR_W-1:0] wr_ptr_d;
  logic [ADDR_W-1:0] rd_ptr_q;
  logic [ADDR_W-1:0] rd_ptr_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CW_W-1:0] head_q;
  logic [CW_W-1:0] head_d;
  logic valid_q;
  logic valid_d;
  logic ready_q;
  logic ready_d;

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Thresholds are captured only while reset is held
  always_ff @(posedge clk) begin
    if (!rst_n_q) begin
      full_thr_q <= prog_full_thresh; // RULE1
      empty_thr_q <= prog_empty_thresh; // RULE2
    end
  end

  // Handshake and pointer control
  wire wr_accept = m_axi_rvalid && ready_q; // RULE9
  wire rd_accept = s_axi_rready && valid_q; // RULE11
  wire wr_refused = m_axi_rvalid && !ready_q; // RULE7
  wire rd_refused = s_axi_rready && !valid_q; // RULE10

  // Encoding and error injection on the write path
  wire [PAY_W-1:0] wr_payload = {m_axi_rid, m_axi_rdata, m_axi_rresp, m_axi_rlast, m_axi_ruser};
  wire [CW_W-1:0] wr_clean = rdata_fifo_pkg::ecc_encode(wr_payload);
  wire inj_double = ecc_enable && inject_double_err;
  wire inj_single = ecc_enable && inject_single_err && !inj_double;
  wire [CW_W-1:0] sb_mask = CW_W'(1) << rdata_fifo_pkg::SB_POS;
  wire [CW_W-1:0] db_mask = sb_mask | (CW_W'(1) << rdata_fifo_pkg::DB_POS);
  wire [CW_W-1:0] wr_word = wr_clean ^ (inj_double ? db_mask : (inj_single ? sb_mask : '0)); // RULE3 RULE4

  assign wr_ptr_d = wr_accept ? wr_ptr_q + rdata_fifo_pkg::PTR_ONE : wr_ptr_q; // RULE8
  assign rd_ptr_d = rd_accept ? rd_ptr_q + rdata_fifo_pkg::PTR_ONE : rd_ptr_q;
  assign count_d = (wr_accept && !rd_accept) ? count_q + rdata_fifo_pkg::CNT_ONE :
                   (rd_accept && !wr_accept) ? count_q - rdata_fifo_pkg::CNT_ONE : count_q;
  assign valid_d = count_d != rdata_fifo_pkg::CNT_RESET;
  assign ready_d = count_d != rdata_fifo_pkg::CNT_FULL;
  assign head_d = (wr_accept && (wr_ptr_q == rd_ptr_d)) ? wr_word : mem_q[rd_ptr_d];

  // Decoding of the next head word
  wire [rdata_fifo_pkg::PAR_W-1:0] syndrome = rdata_fifo_pkg::ecc_syndrome(head_d);
  wire parity_bad = ^head_d;
  wire syn_nz = syndrome != '0;
  wire [CW_W-1:0] fix_mask = (syn_nz && parity_bad) ? (CW_W'(1) << syndrome) : '0;
  wire [PAY_W-1:0] rd_payload = rdata_fifo_pkg::ecc_extract(head_d ^ fix_mask);
  wire single_d = ecc_enable && valid_d && parity_bad; // RULE5
  wire double_d = ecc_enable && valid_d && syn_nz && !parity_bad; // RULE6

  // Threshold compares on the next count
  wire full_d = count_d >= {1'b0, full_thr_q}; // RULE17 RULE18
  wire empty_d = count_d <= {1'b0, empty_thr_q}; // RULE19 RULE20

  // Storage: only accepted writes touch the array
  always_ff @(posedge clk) begin
    if (wr_accept) begin
      mem_q[wr_ptr_q] <= wr_word; // RULE8
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= rdata_fifo_pkg::PTR_RESET;
      rd_ptr_q <= rdata_fifo_pkg::PTR_RESET;
      count_q <= rdata_fifo_pkg::CNT_RESET;
      valid_q <= 1'b0;
      ready_q <= 1'b0;
      head_q <= '0;
    end else if (!rst_n_q) begin
      wr_ptr_q <= rdata_fifo_pkg::PTR_RESET;
      rd_ptr_q <= rdata_fifo_pkg::PTR_RESET;
      count_q <= rdata_fifo_pkg::CNT_RESET;
      valid_q <= 1'b0;
      ready_q <= 1'b0;
      head_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      valid_q <= valid_d;
      ready_q <= ready_d;
      head_q <= head_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {s_axi_rid, s_axi_rdata, s_axi_rresp, s_axi_rlast, s_axi_ruser} <= '0;
      single_err <= 1'b0;
      double_err <= 1'b0;
      overflow <= 1'b0;
      underflow <= 1'b0;
      wr_data_count <= rdata_fifo_pkg::CNT_RESET;
      rd_data_count <= rdata_fifo_pkg::CNT_RESET;
      data_count <= rdata_fifo_pkg::CNT_RESET;
      prog_full <= 1'b0;
      prog_empty <= 1'b1;
    end else if (!rst_n_q) begin
      {s_axi_rid, s_axi_rdata, s_axi_rresp, s_axi_rlast, s_axi_ruser} <= '0;
      single_err <= 1'b0;
      double_err <= 1'b0;
      overflow <= 1'b0;
      underflow <= 1'b0;
      wr_data_count <= rdata_fifo_pkg::CNT_RESET;
      rd_data_count <= rdata_fifo_pkg::CNT_RESET;
      data_count <= rdata_fifo_pkg::CNT_RESET;
      prog_full <= 1'b0;
      prog_empty <= 1'b1;
    end else begin
      {s_axi_rid, s_axi_rdata, s_axi_rresp, s_axi_rlast, s_axi_ruser} <= rd_payload;
      single_err <= single_d; // RULE5
      double_err <= double_d; // RULE6
      overflow <= wr_refused; // RULE7
      underflow <= rd_refused; // RULE10
      wr_data_count <= count_d; // RULE12 RULE13 RULE21
      rd_data_count <= count_d; // RULE14 RULE15 RULE21
      data_count <= count_d; // RULE16
      prog_full <= full_d; // RULE17 RULE18 RULE21
      prog_empty <= empty_d; // RULE19 RULE20 RULE21
    end
  end

  assign m_axi_rready = ready_q;
  assign s_axi_rvalid = valid_q;
endmodule : rdata_fifo
`default_nettype wire

// ===== rdata_fifo_assertions.sv
// Purpose: Port assertions for rdata_fifo
// Assumes: Thresholds move only in reset
// Notes: Bound to every instance
`timescale 1ns/1ps
`default_nettype none
module rdata_fifo_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic m_axi_rvalid,
  input wire logic m_axi_rready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow,
  input wire logic underflow,
  input wire logic prog_full,
  input wire logic prog_empty,
  input wire logic [rdata_fifo_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [rdata_fifo_pkg::THR_W-1:0] prog_full_thresh,
  input wire logic [rdata_fifo_pkg::THR_W-1:0] prog_empty_thresh,
  input wire logic [rdata_fifo_pkg::CNT_W-1:0] data_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire wr_acc = m_axi_rvalid & m_axi_rready;
  wire rd_acc = s_axi_rvalid & s_axi_rready;
  a_ovf_pulse: assert property (1 |=> overflow == $past(m_axi_rvalid & ~m_axi_rready))
    else $error("overflow pulse wrong");
  a_unf_pulse: assert property (1 |=> underflow == $past(s_axi_rready & ~s_axi_rvalid))
    else $error("underflow pulse wrong");
  a_count_up: assert property (wr_acc & ~rd_acc |=> data_count == $past(data_count) + 5'h01)
    else $error("count did not rise");
  a_count_down: assert property (rd_acc & ~wr_acc |=> data_count == $past(data_count) - 5'h01)
    else $error("count did not fall");
  a_count_hold: assert property (~wr_acc & ~rd_acc |=> $stable(data_count))
    else $error("count moved");
  a_pfull_level: assert property (prog_full == (data_count >= {1'b0, prog_full_thresh}))
    else $error("prog_full wrong");
  a_pempty_level: assert property (prog_empty == (data_count <= {1'b0, prog_empty_thresh}))
    else $error("prog_empty wrong");
  a_full_blocks: assert property (data_count == rdata_fifo_pkg::CNT_FULL |-> !m_axi_rready)
    else $error("ready while full");
  a_head_hold: assert property (s_axi_rvalid & ~s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("head word changed");
  c_ovf: cover property (overflow);
  c_unf: cover property (underflow);
  c_pfull: cover property (prog_full);
  c_both: cover property (wr_acc && rd_acc);
endmodule : rdata_fifo_assertions
bind rdata_fifo rdata_fifo_assertions i_chk (.*);
`default_nettype wire

// ===== rd_sink.sv
// Purpose: Read-side sink model
// Assumes: Ready may stall at random
// Notes: Ready may rise while empty
`timescale 1ns/1ps
`default_nettype none
module rd_sink (
  input wire logic clk,
  input wire logic en,
  input wire logic slow,
  output var logic rready
);
  always @(posedge clk) begin
    rready <= en & (~slow | ($urandom % 3 == 0));
  end
endmodule : rd_sink
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for rdata_fifo
// Assumes: Sink model drives the read side
// Notes: Queue model is compared every cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, reset_n = 1'b0, ecc_enable = 1'b0, m_axi_rvalid = 1'b0, m_axi_rlast = 1'b0, en = 1'b0;
  logic inject_single_err = 1'b0, inject_double_err = 1'b0, slow = 1'b0, run = 1'b0, ovf_e = 1'b0, unf_e = 1'b0;
  logic [3:0] m_axi_rid = 4'h0, prog_full_thresh = 4'h5, prog_empty_thresh = 4'h2, s_axi_rid;
  logic [31:0] m_axi_rdata = 32'h0, s_axi_rdata;
  logic [1:0] m_axi_rresp = 2'h0, s_axi_rresp;
  logic [0:0] m_axi_ruser = 1'h0, s_axi_ruser;
  logic s_axi_rlast, s_axi_rvalid, s_axi_rready, m_axi_rready, single_err, double_err, overflow, underflow;
  logic prog_full, prog_empty;
  logic [4:0] wr_data_count, rd_data_count, data_count;
  logic [41:0] q[$];
  logic [41:0] e;
  int fail_count = 0, n_compared = 0;
  rdata_fifo i_dut (.*);
  rd_sink i_sink (.clk(clk), .en(en), .slow(slow), .rready(s_axi_rready));
  initial forever #2 clk = ~clk;
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string n, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wait_for(ref logic s, input logic v);
    int i;
    for (i = 0; i < 200 && s !== v; i++) @(posedge clk);
    if (i == 200) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_for
  task automatic wr(input logic s, input logic d);
    m_axi_rvalid <= 1'b1;
    {m_axi_rid, m_axi_rdata, m_axi_rresp, m_axi_rlast, m_axi_ruser} <= 40'({$urandom, $urandom});
    inject_single_err <= s;
    inject_double_err <= d;
    @(posedge clk);
    wait_for(m_axi_rready, 1'b1);
  endtask : wr
  task automatic do_reset(input logic [3:0] f, input logic [3:0] t);
    run <= 1'b0;
    reset_n <= 1'b0;
    prog_full_thresh <= f;
    prog_empty_thresh <= t;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    wait_for(m_axi_rready, 1'b1);
    run <= 1'b1;
  endtask : do_reset
  always @(posedge clk) begin
    if (run) begin
      check("counts", {wr_data_count, rd_data_count, data_count}, {3{5'(q.size())}});
      check("prog_full", prog_full, q.size() >= prog_full_thresh);
      check("prog_empty", prog_empty, q.size() <= prog_empty_thresh);
      check("overflow", overflow, ovf_e);
      check("underflow", underflow, unf_e);
      check("ready_valid", {m_axi_rready, s_axi_rvalid}, {q.size() < 16, q.size() != 0});
      if (s_axi_rvalid && s_axi_rready) begin
        e = q.pop_front();
        check("single_err", single_err, e[41:40] == 2'h1);
        check("double_err", double_err, e[41:40] == 2'h2);
        if (e[41:40] != 2'h2) check("head", {s_axi_rid, s_axi_rdata, s_axi_rresp, s_axi_rlast, s_axi_ruser}, e[39:0]);
      end
      if (m_axi_rvalid && m_axi_rready) begin
        e[39:0] = {m_axi_rid, m_axi_rdata, m_axi_rresp, m_axi_rlast, m_axi_ruser};
        e[41:40] = ecc_enable ? (inject_double_err ? 2'h2 : {1'b0, inject_single_err}) : 2'h0;
        q.push_back(e);
      end
      ovf_e = m_axi_rvalid & ~m_axi_rready;
      unf_e = s_axi_rready & ~s_axi_rvalid;
    end else begin
      q.delete();
      ovf_e = 1'b0;
      unf_e = 1'b0;
    end
  end
  initial begin
    void'($urandom(32'h1da2));
    for (int ph = 0; ph < 2; ph++) begin
      do_reset(ph ? 4'hf : 4'h5, ph ? 4'h0 : 4'h2);
      ecc_enable <= (ph == 0);
      repeat (16) wr(1'($urandom), 1'($urandom));
      repeat (2) @(posedge clk);
      m_axi_rvalid <= 1'b0;
      en <= 1'b1;
      slow <= 1'b1;
      wait_for(s_axi_rvalid, 1'b0);
      slow <= 1'b0;
      repeat (3) @(posedge clk);
      slow <= (ph == 0);
      repeat (40) wr(1'($urandom), 1'($urandom));
      m_axi_rvalid <= 1'b0;
      wait_for(s_axi_rvalid, 1'b0);
      en <= 1'b0;
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
